// file: fpsi_pkg.sv
package fpsi_pkg;
   // =====================================================
   // timing
   localparam int unsigned CLK_MHZ = 125;
   localparam int unsigned STRETCH_MS = 100;
   // stretch count in cycles, 100 ms at 125 MHz
   localparam int unsigned STRETCH_CYCLES = STRETCH_MS * 1000 * CLK_MHZ;
   localparam int unsigned STRETCH_W = 24;
   // presence: width of the age counter; a clock-alive strobe must repeat within 256 cycles
   localparam int unsigned ALIVE_W = 8;

   // =====================================================
   // register map
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_IRQ_STATUS = 8'h04;
   localparam logic [7:0] REG_IRQ_MASK = 8'h08;
   localparam logic [7:0] REG_ERR_ENABLE = 8'h0C;
   localparam logic [7:0] REG_CODE_BASE = 8'h10;
   localparam logic [7:0] REG_CODE_LAST = 8'h2C;
   localparam int unsigned ERR_SRC_N = 8;
   localparam logic [7:0] ERR_ENABLE_RESET = 8'hFF;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

   // irq status bit positions
   localparam int unsigned IRQ_ERR = 0;
   localparam int unsigned IRQ_LOAD_FAIL = 1;
   localparam int unsigned IRQ_SUPPLY_BAD = 2;
   localparam int unsigned IRQ_N = 3;

   // character code reset value: blank
   localparam logic [7:0] CHAR_BLANK = 8'h20;

   typedef struct packed {
      logic merger_ok;
      logic merger_fail;
      logic cp_rep_ok;
      logic cp_rep_fail;
      logic jet_rep_ok;
      logic jet_rep_fail;
   } fpsi_load_t;

   typedef struct packed {
      logic load_merger_green;
      logic load_merger_red;
      logic load_cp_green;
      logic load_cp_red;
      logic load_jet_green;
      logic load_jet_red;
      logic crate_supply_green;
      logic board_supply_green;
      logic bus_activity_yellow;
      logic accept_yellow;
      logic sys_clock_green;
      logic readout_yellow;
      logic local_clock_yellow;
      logic error_red;
   } fpsi_leds_t;
endpackage

// file: fpsi_stretch.sv
`timescale 1ns/100ps
// =====================================================
// pulse stretcher: holds out high for a fixed count after last trigger
module fpsi_stretch #(
   parameter int unsigned CYCLES = fpsi_pkg::STRETCH_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // trigger and stretched level
   input wire logic trig,
   output logic out
);
   localparam logic [fpsi_pkg::STRETCH_W-1:0] LOAD = fpsi_pkg::STRETCH_W'(CYCLES - 1);
   logic [fpsi_pkg::STRETCH_W-1:0] count;
   wire running = (count != '0);
   // reload on every trigger so bursts keep the lamp lit
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count <= '0;
         out <= 1'b0;
      end else if (trig) begin
         count <= LOAD;
         out <= 1'b1;
      end else begin
         count <= running ? count - 1'b1 : count;
         out <= running;
      end
   end
endmodule

// file: fpsi_alive.sv
`timescale 1ns/100ps
// =====================================================
// presence detector: level high while strobes keep arriving
module fpsi_alive (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // tick from the monitored source and presence level
   input wire logic tick,
   output logic present
);
   logic [fpsi_pkg::ALIVE_W-1:0] age;
   wire expired = &age;
   // saturating age counter; a stalled source lets it reach all ones
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         age <= '1;
         present <= 1'b0;
      end else begin
         age <= tick ? '0 : (expired ? age : age + 1'b1);
         present <= tick | ~expired;
      end
   end
endmodule

// file: fpsi_top.sv
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/100ps
// How it works
// - each bus data-acknowledge lights yellow bus lamp for 100 ms
// - each trigger accept lights yellow accept lamp for 100 ms
// - green system-clock lamp lit while distributed clock present, stretched 100 ms
// - yellow local-clock lamp lit while crystal clock used, stretched 100 ms
// - red error lamp is OR of the module error sources enabled in err_enable
// - three load lamps: merger, cp and jet repeaters; green ok, red fail
// - yellow readout lamp lit while merger sends data on serial link
// - green lamp shows crate supply voltages correct
// - separate green lamp shows on-board voltages correct
// - matrix display shows error state as configurable character code
module fpsi_top (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // status sources
   input wire logic bus_dtack,
   input wire logic trigger_accept,
   input wire logic sys_clock_tick,
   input wire logic local_clock_sel,
   input wire fpsi_pkg::fpsi_load_t load_status,
   input wire logic readout_merger_sending,
   input wire logic crate_supply_ok,
   input wire logic board_supply_ok,
   input wire logic [fpsi_pkg::ERR_SRC_N-1:0] err_src,
   // indicators
   output fpsi_pkg::fpsi_leds_t leds,
   output logic [7:0] matrix_char,
   output logic irq
);
   // =====================================================
   // registers
   logic [fpsi_pkg::ERR_SRC_N-1:0] err_enable;
   logic [fpsi_pkg::IRQ_N-1:0] irq_status;
   logic [fpsi_pkg::IRQ_N-1:0] irq_mask;
   logic [7:0] code_table [fpsi_pkg::ERR_SRC_N];

   // =====================================================
   // stretched event and clock lamps
   logic bus_lit;
   logic acc_lit;
   logic sys_present;
   logic sys_lit;
   logic loc_lit;

   fpsi_stretch #(.CYCLES(fpsi_pkg::STRETCH_CYCLES)) u_bus (
      .clk(clk),
      .rst(rst),
      .trig(bus_dtack),
      .out(bus_lit)
   );
   fpsi_stretch #(.CYCLES(fpsi_pkg::STRETCH_CYCLES)) u_acc (
      .clk(clk),
      .rst(rst),
      .trig(trigger_accept),
      .out(acc_lit)
   );
   // system clock seen as a stream of ticks from the distributed clock
   fpsi_alive u_sys_alive (
      .clk(clk),
      .rst(rst),
      .tick(sys_clock_tick),
      .present(sys_present)
   );
   fpsi_stretch #(.CYCLES(fpsi_pkg::STRETCH_CYCLES)) u_sys (
      .clk(clk),
      .rst(rst),
      .trig(sys_present),
      .out(sys_lit)
   );
   fpsi_stretch #(.CYCLES(fpsi_pkg::STRETCH_CYCLES)) u_loc (
      .clk(clk),
      .rst(rst),
      .trig(local_clock_sel),
      .out(loc_lit)
   );

   // =====================================================
   // error summary and display code
   wire [fpsi_pkg::ERR_SRC_N-1:0] err_active = err_src & err_enable;
   wire any_err = |err_active;
   // lowest-numbered active source wins the display
   logic [2:0] first_err;
   always_comb begin
      first_err = 3'h0;
      for (int i = fpsi_pkg::ERR_SRC_N - 1; i >= 0; i--) begin
         if (err_active[i]) begin
            first_err = 3'(i);
         end
      end
   end
   wire [7:0] next_char = any_err ? code_table[first_err] : fpsi_pkg::CHAR_BLANK;

   wire load_fail = load_status.merger_fail | load_status.cp_rep_fail
      | load_status.jet_rep_fail;
   wire supply_bad = ~crate_supply_ok | ~board_supply_ok;
   wire [fpsi_pkg::IRQ_N-1:0] irq_events = {supply_bad, load_fail, any_err};

   // =====================================================
   // indicator assembly
   fpsi_pkg::fpsi_leds_t next_leds;
   always_comb begin
      next_leds.load_merger_green = load_status.merger_ok;
      next_leds.load_merger_red = load_status.merger_fail;
      next_leds.load_cp_green = load_status.cp_rep_ok;
      next_leds.load_cp_red = load_status.cp_rep_fail;
      next_leds.load_jet_green = load_status.jet_rep_ok;
      next_leds.load_jet_red = load_status.jet_rep_fail;
      next_leds.crate_supply_green = crate_supply_ok;
      next_leds.board_supply_green = board_supply_ok;
      next_leds.bus_activity_yellow = bus_lit;
      next_leds.accept_yellow = acc_lit;
      next_leds.sys_clock_green = sys_lit;
      next_leds.readout_yellow = readout_merger_sending;
      next_leds.local_clock_yellow = loc_lit;
      next_leds.error_red = any_err;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         leds <= '0;
         matrix_char <= fpsi_pkg::CHAR_BLANK;
      end else begin
         leds <= next_leds;
         matrix_char <= next_char;
      end
   end

   // =====================================================
   // register decode
   wire sel_status = (reg_addr == fpsi_pkg::REG_STATUS);
   wire sel_irq_status = (reg_addr == fpsi_pkg::REG_IRQ_STATUS);
   wire sel_irq_mask = (reg_addr == fpsi_pkg::REG_IRQ_MASK);
   wire sel_err_enable = (reg_addr == fpsi_pkg::REG_ERR_ENABLE);
   wire sel_code = (reg_addr >= fpsi_pkg::REG_CODE_BASE)
      && (reg_addr <= fpsi_pkg::REG_CODE_LAST) && (reg_addr[1:0] == 2'b00);
   wire [2:0] code_idx = 3'((reg_addr - fpsi_pkg::REG_CODE_BASE) >> 2);

   // irq status: set wins over write-one-to-clear
   wire [fpsi_pkg::IRQ_N-1:0] w1c = (reg_wr && sel_irq_status)
      ? reg_wdata[fpsi_pkg::IRQ_N-1:0] : '0;
   wire [fpsi_pkg::IRQ_N-1:0] next_irq_status = (irq_status & ~w1c) | irq_events;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_status <= '0;
         irq_mask <= '0;
         err_enable <= fpsi_pkg::ERR_ENABLE_RESET;
         irq <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         irq <= |(next_irq_status & irq_mask);
         if (reg_wr && sel_irq_mask) begin
            irq_mask <= reg_wdata[fpsi_pkg::IRQ_N-1:0];
         end
         if (reg_wr && sel_err_enable) begin
            err_enable <= reg_wdata[fpsi_pkg::ERR_SRC_N-1:0];
         end
      end
   end

   // code table, configurable since the meanings are open
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < fpsi_pkg::ERR_SRC_N; i++) begin
            code_table[i] <= 8'(8'h30 + i);
         end
      end else if (reg_wr && sel_code) begin
         code_table[code_idx] <= reg_wdata[7:0];
      end
   end

   // =====================================================
   // read mux, one cycle latency
   // status word: character, raw error levels, two spare bits, lamp levels
   wire [31:0] status_word = {matrix_char, err_src, 2'b00, leds};
   logic [31:0] next_rdata;
   always_comb begin
      if (sel_status) begin
         next_rdata = status_word;
      end else if (sel_irq_status) begin
         next_rdata = {29'h0000_0000, irq_status};
      end else if (sel_irq_mask) begin
         next_rdata = {29'h0000_0000, irq_mask};
      end else if (sel_err_enable) begin
         next_rdata = {24'h00_0000, err_enable};
      end else if (sel_code) begin
         next_rdata = {24'h00_0000, code_table[code_idx]};
      end else begin
         next_rdata = fpsi_pkg::UNMAPPED_READ;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= reg_rd ? next_rdata : 32'h0000_0000;
      end
   end
endmodule

// file: fpsi_props.sv
`timescale 1ns/100ps
// =====================================================
// port checker for the front panel lamps
module fpsi_props (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // status sources
   input wire logic bus_dtack,
   input wire logic trigger_accept,
   input wire logic sys_clock_tick,
   input wire logic local_clock_sel,
   input wire fpsi_pkg::fpsi_load_t load_status,
   input wire logic readout_merger_sending,
   input wire logic crate_supply_ok,
   input wire logic board_supply_ok,
   input wire logic [fpsi_pkg::ERR_SRC_N-1:0] err_src,
   // indicators
   input wire fpsi_pkg::fpsi_leds_t leds,
   input wire logic [7:0] matrix_char
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic [23:0] since_acc;
   // cycles since the last accept; saturates so reset never looks like a fresh event
   always_ff @(posedge clk or posedge rst) begin
      if (rst) since_acc <= 24'hFFFFFF;
      else if (trigger_accept) since_acc <= 24'h000000;
      else if (since_acc != 24'hFFFFFF) since_acc <= since_acc + 24'h000001;
   end
   // stretcher flop then lamp flop: two cycles; the clock lamp adds the presence flop
   bus_lamp_a:
      assert property (bus_dtack |-> ##2 leds.bus_activity_yellow)
         else $error("bus lamp dark");
   accept_lamp_a:
      assert property (trigger_accept |-> ##2 leds.accept_yellow)
         else $error("accept lamp dark");
   sys_lamp_a:
      assert property (sys_clock_tick |-> ##3 leds.sys_clock_green)
         else $error("sys lamp dark");
   local_lamp_a:
      assert property (local_clock_sel |-> ##2 leds.local_clock_yellow)
         else $error("local lamp dark");
   error_lamp_a:
      assert property (!$past(rst) |-> leds.error_red == |$past(err_src)) else $error("red lamp");
   load_lamps_a:
      assert property (!$past(rst) |-> leds[13:8] == $past(load_status)) else $error("load lamps");
   readout_lamp_a:
      assert property (!$past(rst) |-> leds.readout_yellow == $past(readout_merger_sending))
         else $error("readout lamp");
   supply_lamps_a:
      assert property (!$past(rst) |-> leds.crate_supply_green == $past(crate_supply_ok)
         && leds.board_supply_green == $past(board_supply_ok)) else $error("supply lamps");
   blank_char_a:
      assert property (err_src == '0 |=> matrix_char == 8'h20) else $error("char not blank");
   stretch_hold_a:
      assert property ($fell(leds.accept_yellow)
         |-> {8'h00, since_acc} >= fpsi_pkg::STRETCH_CYCLES - 2)
         else $error("accept lamp dropped early");
   accept_held_a:
      assert property (since_acc != 24'h000000
         && {8'h00, since_acc} <= fpsi_pkg::STRETCH_CYCLES |-> leds.accept_yellow)
         else $error("accept lamp dark inside stretch");
endmodule

bind fpsi_top fpsi_props fpsi_props_i (
   .clk(clk),
   .rst(rst),
   .bus_dtack(bus_dtack),
   .trigger_accept(trigger_accept),
   .sys_clock_tick(sys_clock_tick),
   .local_clock_sel(local_clock_sel),
   .load_status(load_status),
   .readout_merger_sending(readout_merger_sending),
   .crate_supply_ok(crate_supply_ok),
   .board_supply_ok(board_supply_ok),
   .err_src(err_src),
   .leds(leds),
   .matrix_char(matrix_char)
);

// file: fpsi_panel.sv
`timescale 1ns/100ps
// =====================================================
// front panel model: one character cell and a lit-time meter
module fpsi_panel (
   // clock
   input wire logic clk,
   // indicator drive
   input wire fpsi_pkg::fpsi_leds_t leds,
   input wire logic [7:0] matrix_char,
   // what a viewer sees
   output logic [7:0] shown_char,
   output logic [31:0] bus_lit
);
   // the cell latches each code; lit time shows whether a short event stayed visible
   always @(posedge clk) begin
      shown_char <= matrix_char;
      bus_lit <= leds.bus_activity_yellow ? bus_lit + 32'h1 : 32'h0;
   end
endmodule

// file: testbench.sv
`timescale 1ns/100ps
// =====================================================
// self-checking bench for the front panel block
module testbench;
   logic clk, rst, reg_wr, reg_rd, bus_dtack, trigger_accept, sys_clock_tick, irq;
   logic local_clock_sel, readout_merger_sending, crate_supply_ok, board_supply_ok;
   logic [7:0] reg_addr, matrix_char, shown_char, err_src;
   logic [31:0] reg_wdata, reg_rdata, bus_lit, rd_val;
   fpsi_pkg::fpsi_load_t load_status;
   fpsi_pkg::fpsi_leds_t leds;
   int n_fail, n_tests;
   fpsi_top fpsi_top_i (
      .clk(clk),
      .rst(rst),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .bus_dtack(bus_dtack),
      .trigger_accept(trigger_accept),
      .sys_clock_tick(sys_clock_tick),
      .local_clock_sel(local_clock_sel),
      .load_status(load_status),
      .readout_merger_sending(readout_merger_sending),
      .crate_supply_ok(crate_supply_ok),
      .board_supply_ok(board_supply_ok),
      .err_src(err_src),
      .leds(leds),
      .matrix_char(matrix_char),
      .irq(irq)
   );
   fpsi_panel fpsi_panel_i (
      .clk(clk),
      .leds(leds),
      .matrix_char(matrix_char),
      .shown_char(shown_char),
      .bus_lit(bus_lit)
   );
   // 8 ns clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // hang guard, well past the longest sequence
   initial begin
      #800000;
      n_fail++;
      wrap_up();
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("tests %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // register port: one-cycle strobes; read data taken at the edge closing the data cycle
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      rd_val = reg_rdata;
   endtask
   // lowest active source wins; table reset codes are 0x30 plus the index
   function automatic logic [7:0] exp_char(input logic [7:0] e);
      exp_char = 8'h20;
      for (int i = 7; i >= 0; i--) begin
         if (e[i]) exp_char = 8'h30 + 8'(i);
      end
   endfunction
   // main sequence
   initial begin
      {reg_wr, reg_rd, bus_dtack, trigger_accept, sys_clock_tick, local_clock_sel} = '0;
      {readout_merger_sending, crate_supply_ok, board_supply_ok} = '0;
      {reg_addr, err_src, reg_wdata} = '0;
      load_status = '0;
      n_fail = 0;
      n_tests = 0;
      rst = 1'b1;
      void'($urandom(14967));
      cyc(5);
      rst <= 1'b0;
      cyc(2);
      chk(leds, 32'h0);
      chk(matrix_char, 32'h20);
      chk(irq, 32'h0);
      $display("reset test done");
      for (int k = 0; k < 24; k++) begin
         @(posedge clk);
         load_status <= 6'($urandom);
         err_src <= (k < 2) ? 8'(k * 128) : 8'($urandom);
         {readout_merger_sending, crate_supply_ok, board_supply_ok} <= 3'($urandom);
         cyc(3);
         @(negedge clk);
         chk(leds[13:8], load_status);
         chk(leds.crate_supply_green, crate_supply_ok);
         chk(leds.board_supply_green, board_supply_ok);
         chk(leds.readout_yellow, readout_merger_sending);
         chk(leds.error_red, |err_src);
         chk(shown_char, exp_char(err_src));
      end
      $display("level test done");
      @(posedge clk);
      {bus_dtack, trigger_accept, local_clock_sel} <= 3'h7;
      for (int k = 0; k < 20; k++) begin
         @(posedge clk);
         {bus_dtack, trigger_accept} <= 2'h0;
         sys_clock_tick <= 1'b1;
         @(posedge clk);
         sys_clock_tick <= 1'b0;
         bus_dtack <= (k == 10);
         cyc(100);
      end
      chk(bus_lit > 32'h76C, 32'h1);
      chk(leds.accept_yellow, 32'h1);
      chk(leds.sys_clock_green, 32'h1);
      chk(leds.local_clock_yellow, 32'h1);
      $display("stretch test done");
      @(posedge clk);
      load_status <= 6'h2A;
      {crate_supply_ok, board_supply_ok, err_src} <= 10'h300;
      cyc(3);
      wr(fpsi_pkg::REG_IRQ_STATUS, 32'h7);
      wr(fpsi_pkg::REG_IRQ_MASK, 32'h1);
      wr(fpsi_pkg::REG_CODE_BASE + 8'h04, 32'h41);
      rd(fpsi_pkg::REG_IRQ_STATUS);
      chk(rd_val, 32'h0);
      chk(irq, 32'h0);
      err_src <= 8'h06;
      cyc(3);
      chk(shown_char, 32'h41);
      chk(irq, 32'h1);
      err_src <= 8'h00;
      wr(fpsi_pkg::REG_IRQ_MASK, 32'h0);
      cyc(3);
      chk(irq, 32'h0);
      rd(fpsi_pkg::REG_IRQ_STATUS);
      chk(rd_val, 32'h1);
      wr(fpsi_pkg::REG_IRQ_STATUS, 32'h1);
      rd(fpsi_pkg::REG_IRQ_STATUS);
      chk(rd_val, 32'h0);
      rd(8'hF0);
      chk(rd_val, 32'h0);
      rd(fpsi_pkg::REG_ERR_ENABLE);
      chk(rd_val, 32'hFF);
      rd(fpsi_pkg::REG_STATUS);
      chk(rd_val, {8'h20, 8'h00, 2'b00, leds});
      $display("register test done");
      wrap_up();
   end
endmodule
